// [logic/pfm_top.sv]
/*
 Feedback multiplier configuration for the first PLL: four configuration
 sets, set selection and total multiplier output.
 Assumes a byte register port on mclk_in; select pins are asynchronous.
*/
// Our own choice: the plain strobed port.
// How it works
// - Four sets each hold a 12-bit integer feedback value, reset to zero.
// - Each set holds a 4-bit addend, reset to zero.
// - With spread on, multiplier is 2N plus addend plus one plus offset over 64.
// - Zero addend without spread gives exactly 2N.
// - Nonzero addend without spread gives 2N plus addend plus one.
// - Set zero is used when select inputs are off in multi-function mode.
// - Spread offset comes from registers at 0x60 to 0x63.
`timescale 1ns/1ps
`default_nettype none
module pfm_top #(
    parameter int NUM_CFG = pfm_pkg::PFM_NUM_CFG
) (
    // Clock and reset
    input  wire logic                        mclk_in,
    input  wire logic                        rstn_in,
    // Register port
    input  wire logic [pfm_pkg::PFM_ADDR_W-1:0] reg_addr_in,
    input  wire logic [pfm_pkg::PFM_DATA_W-1:0] reg_wdata_in,
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    output logic [pfm_pkg::PFM_DATA_W-1:0]   reg_rdata_out,
    // Set selection pins
    input  wire logic [1:0]                  config_select_inputs_in,
    input  wire logic                        config_select_enable_in,
    input  wire logic                        multi_function_control_mode_in,
    // Result
    output logic [pfm_pkg::PFM_MUL_W-1:0]    pll0_total_multiplier_out,
    output logic [1:0]                       active_config_out
);
    import pfm_pkg::*;

    if (NUM_CFG != PFM_NUM_CFG) begin : g_bad_cfg
        $error("pfm_top serves exactly four configuration sets");
    end

    logic [PFM_INT_W-1:0] pll0_feedback_integer_reg [NUM_CFG];
    logic [PFM_ADD_W-1:0] pll0_feedback_addend_reg  [NUM_CFG];
    logic [PFM_OFS_W-1:0] spread_fraction_offset_reg [NUM_CFG];
    logic                 spread_enable_reg;
    logic [3:0]           sel_sync1_reg;
    logic [3:0]           sel_sync2_reg;
    pfm_sel_type          sel_reg;
    pfm_sel_type          sel_next;
    logic [PFM_DATA_W-1:0] rdata_next;

    pfm_calc_if calc_bus ();

    // Select pins come from outside the clock domain
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_sync1_reg <= 4'h0;
            sel_sync2_reg <= 4'h0;
        end else begin
            sel_sync1_reg <= {multi_function_control_mode_in, config_select_enable_in,
                              config_select_inputs_in};
            sel_sync2_reg <= sel_sync1_reg;
        end
    end

    always_comb begin
        if (sel_sync2_reg[3] && !sel_sync2_reg[2]) begin
            sel_next = 2'h0;
        end else if (sel_sync2_reg[2]) begin
            sel_next = sel_sync2_reg[1:0];
        end else begin
            sel_next = 2'h0;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_reg <= 2'h0;
        end else begin
            sel_reg <= sel_next;
        end
    end

    // Per-set storage; byte writes land on the addressed set only
    for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
        always_ff @(posedge mclk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                pll0_feedback_integer_reg[i]  <= 12'h000;
                pll0_feedback_addend_reg[i]   <= 4'h0;
                spread_fraction_offset_reg[i] <= PFM_RESET_VAL;
            end else if (reg_wr_in) begin
                if (reg_addr_in == PFM_OFF_LOW0 + 8'(i)) begin
                    pll0_feedback_integer_reg[i][7:0] <= reg_wdata_in;
                end
                if (reg_addr_in == PFM_OFF_HIGH0 + 8'(i)) begin
                    pll0_feedback_integer_reg[i][11:8] <=
                        reg_wdata_in[PFM_HIGH_INT_LSB +: 4];
                    pll0_feedback_addend_reg[i] <=
                        reg_wdata_in[PFM_HIGH_ADD_LSB +: PFM_ADD_W];
                end
                if (reg_addr_in == PFM_OFF_SPREAD0 + 8'(i)) begin
                    spread_fraction_offset_reg[i] <= reg_wdata_in;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            spread_enable_reg <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == PFM_OFF_SPREAD_EN) begin
            spread_enable_reg <= reg_wdata_in[0];
        end
    end

    // Selected set feeds the calculator
    assign calc_bus.integer_val = pll0_feedback_integer_reg[sel_reg];
    assign calc_bus.addend_val  = pll0_feedback_addend_reg[sel_reg];
    assign calc_bus.offset_val  = spread_fraction_offset_reg[sel_reg];
    assign calc_bus.spread_on   = spread_enable_reg;

    pfm_mult_calc u_calc (
        .mclk_in (mclk_in),
        .rstn_in (rstn_in),
        .calc    (calc_bus.calc)
    );

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pll0_total_multiplier_out <= 20'h00000;
            active_config_out         <= 2'h0;
        end else begin
            pll0_total_multiplier_out <= calc_bus.multiplier;
            active_config_out         <= sel_reg;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = 8'h00;
        for (int j = 0; j < NUM_CFG; j++) begin
            if (reg_addr_in == PFM_OFF_LOW0 + 8'(j)) begin
                rdata_next = pll0_feedback_integer_reg[j][7:0];
            end
            if (reg_addr_in == PFM_OFF_HIGH0 + 8'(j)) begin
                rdata_next = {pll0_feedback_addend_reg[j], pll0_feedback_integer_reg[j][11:8]};
            end
            if (reg_addr_in == PFM_OFF_SPREAD0 + 8'(j)) begin
                rdata_next = spread_fraction_offset_reg[j];
            end
        end
        if (reg_addr_in == PFM_OFF_SPREAD_EN) begin
            rdata_next = {7'h00, spread_enable_reg};
        end
        if (reg_addr_in == PFM_OFF_STATUS) begin
            rdata_next = {6'h00, sel_reg};
        end
        if (reg_addr_in == PFM_OFF_MUL_LO) begin
            rdata_next = pll0_total_multiplier_out[7:0];
        end
        if (reg_addr_in == PFM_OFF_MUL_HI) begin
            rdata_next = pll0_total_multiplier_out[15:8];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_next;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // Assertions
    AST_RESET_ZERO: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        $rose(rstn_in) |-> calc_bus.integer_val == 12'h000 && calc_bus.addend_val == 4'h0
        && pll0_total_multiplier_out == 20'h00000)
        else $error("Set values or multiplier not zero after reset");
    AST_ADDEND_WRITE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        reg_wr_in && reg_addr_in == PFM_OFF_HIGH0 |=>
        pll0_feedback_addend_reg[0] == $past(reg_wdata_in[PFM_HIGH_ADD_LSB +: PFM_ADD_W]))
        else $error("Addend write not stored");
    AST_PLAIN_DOUBLE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        calc_bus.addend_val == 4'h0 && !calc_bus.spread_on |=>
        calc_bus.multiplier == 20'($past(calc_bus.integer_val)) << 7)
        else $error("Zero addend multiplier wrong");
    AST_ADDEND_PLUS: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        calc_bus.addend_val != 4'h0 && !calc_bus.spread_on |=>
        calc_bus.multiplier == (20'($past(calc_bus.integer_val)) * 20'h2
        + 20'($past(calc_bus.addend_val)) + 20'h1) << 6)
        else $error("Nonzero addend multiplier wrong");
    AST_SPREAD_FRAC: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        calc_bus.spread_on |=>
        calc_bus.multiplier[5:0] == $past(calc_bus.offset_val[5:0]))
        else $error("Spread fraction wrong");
    AST_MFC_SET0: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        sel_sync2_reg[3] && !sel_sync2_reg[2] |=> sel_reg == 2'h0)
        else $error("Set zero not chosen in multi-function mode");
    AST_SPREAD_STORE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        reg_wr_in && reg_addr_in == PFM_OFF_SPREAD0 + 8'h01 |=>
        spread_fraction_offset_reg[1] == $past(reg_wdata_in))
        else $error("Spread offset not stored");
    // Output follows sel_reg one cycle later, so compare against its previous value
    AST_SEL_PINS: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        sel_sync2_reg[2] |=> sel_reg == $past(sel_sync2_reg[1:0])
        ##1 active_config_out == $past(sel_reg))
        else $error("Selected set not applied");
    AST_READ_ONE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("Read data held too long");

    COV_SPREAD: cover property (@(posedge mclk_in) disable iff (!rstn_in)
        calc_bus.spread_on && calc_bus.offset_val != 8'h00);
    COV_SET3: cover property (@(posedge mclk_in) disable iff (!rstn_in) sel_reg == 2'h3);
    COV_ADDEND: cover property (@(posedge mclk_in) disable iff (!rstn_in)
        calc_bus.addend_val != 4'h0 && !calc_bus.spread_on);
    COV_MFC_SET0: cover property (@(posedge mclk_in) disable iff (!rstn_in)
        sel_sync2_reg[3] && !sel_sync2_reg[2]);
endmodule
`default_nettype wire

// [logic/pfm_pkg.sv]
/*
 Constants for the first-PLL feedback multiplier configuration block:
 register offsets, field positions, reset values and widths.
 Assumes a plain single-clock register port with byte-wide data.
*/
`default_nettype none
package pfm_pkg;
    localparam int          PFM_NUM_CFG       = 4;
    localparam int          PFM_INT_W         = 12;
    localparam int          PFM_ADD_W         = 4;
    localparam int          PFM_OFS_W         = 8;
    localparam int          PFM_MUL_W         = 20;  // Integer part 14 bits, fraction 6 bits
    localparam int          PFM_FRAC_BITS     = 6;   // Offset is scaled by 1/64
    localparam int          PFM_ADDR_W        = 8;
    localparam int          PFM_DATA_W        = 8;
    localparam logic [7:0]  PFM_OFF_LOW0      = 8'h14;
    localparam logic [7:0]  PFM_OFF_LOW1      = 8'h15;
    localparam logic [7:0]  PFM_OFF_LOW2      = 8'h16;
    localparam logic [7:0]  PFM_OFF_LOW3      = 8'h17;
    localparam logic [7:0]  PFM_OFF_HIGH0     = 8'h18;
    localparam logic [7:0]  PFM_OFF_HIGH1     = 8'h19;
    localparam logic [7:0]  PFM_OFF_HIGH2     = 8'h1A;
    localparam logic [7:0]  PFM_OFF_HIGH3     = 8'h1B;
    localparam logic [7:0]  PFM_OFF_SPREAD0   = 8'h60;  // 0x60..0x63 offsets per set
    localparam logic [7:0]  PFM_OFF_SPREAD_EN = 8'h64;  // Bit 0 enables spread
    localparam logic [7:0]  PFM_OFF_STATUS    = 8'h65;  // Active set in bits 1:0
    localparam logic [7:0]  PFM_OFF_MUL_LO    = 8'h66;
    localparam logic [7:0]  PFM_OFF_MUL_HI    = 8'h67;
    localparam logic [7:0]  PFM_RESET_VAL     = 8'h00;
    localparam int          PFM_HIGH_INT_LSB  = 0;
    localparam int          PFM_HIGH_ADD_LSB  = 4;
    typedef logic [1:0] pfm_sel_type;
endpackage
`default_nettype wire

// [logic/pfm_calc_if.sv]
/*
 Interface carrying the selected set's values to the multiplier calculator
 and the result back. Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface pfm_calc_if;
    logic [11:0] integer_val;
    logic [3:0]  addend_val;
    logic [7:0]  offset_val;
    logic        spread_on;
    logic [19:0] multiplier;
    modport ctrl (output integer_val, output addend_val, output offset_val,
                  output spread_on, input multiplier);
    modport calc (input integer_val, input addend_val, input offset_val,
                  input spread_on, output multiplier);
endinterface
`default_nettype wire

// [logic/pfm_mult_calc.sv]
/*
 Registered total multiplier calculator in 1/64 fixed point.
 Assumes inputs are steady values from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pfm_mult_calc (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    // Values in, result out
    pfm_calc_if.calc  calc
);
    import pfm_pkg::*;
    logic [19:0] mul_next;

    always_comb begin
        if (calc.addend_val == 4'h0 && !calc.spread_on) begin
            mul_next = {7'h00, calc.integer_val, 1'b0} << PFM_FRAC_BITS;
        end else begin
            // Whole part 2N+A+1, offset already in 1/64 units
            mul_next = (20'({calc.integer_val, 1'b0}) + 20'(calc.addend_val) + 20'h00001)
                       << PFM_FRAC_BITS;
            if (calc.spread_on) begin
                mul_next = mul_next + 20'(calc.offset_val);
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            calc.multiplier <= 20'h00000;
        end else begin
            calc.multiplier <= mul_next;
        end
    end
endmodule
`default_nettype wire

// [testbench/pfm_top_tb.sv]
/*
 Self-checking bench for pfm_top: register access, multiplier formula
 and configuration set selection.
 Assumes the register port and pipeline latencies of pfm_top.
*/
`timescale 1ns/1ps
`default_nettype none
module pll0_feedback_multiplier_cfg_tb_top;
    import pfm_pkg::*;
    logic        mclk_in    = 1'b0;
    logic        rstn_in    = 1'b0;
    logic [7:0]  addr       = 8'h00;
    logic [7:0]  wdata      = 8'h00;
    logic        wr_s       = 1'b0;
    logic        rd_s       = 1'b0;
    logic [7:0]  rdata;
    logic [1:0]  sel        = 2'h0;
    logic        sel_en     = 1'b0;
    logic        multi_function_control_mode        = 1'b1;
    logic [19:0] mul;
    logic [1:0]  act;
    int          err_total  = 0;
    int          n_compared = 0;

    always #50 mclk_in = ~mclk_in;

    pfm_top dut (
        .mclk_in                        (mclk_in),
        .rstn_in                        (rstn_in),
        .reg_addr_in                    (addr),
        .reg_wdata_in                   (wdata),
        .reg_wr_in                      (wr_s),
        .reg_rd_in                      (rd_s),
        .reg_rdata_out                  (rdata),
        .config_select_inputs_in        (sel),
        .config_select_enable_in        (sel_en),
        .multi_function_control_mode_in (multi_function_control_mode),
        .pll0_total_multiplier_out      (mul),
        .active_config_out              (act)
    );

    task automatic report(input logic [19:0] g, input logic [19:0] e);
        err_total++;
        $display("Error at %0t: got %h expected %h", $time, g, e);
    endtask
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) report({12'h000, g}, {12'h000, e});
    endtask
    task automatic chk_mul(input logic [19:0] e);
        n_compared++;
        if (mul !== e) report(mul, e);
    endtask
    task automatic chk_sel(input logic [1:0] e);
        n_compared++;
        if (act !== e) report({18'h00000, act}, {18'h00000, e});
    endtask

    // Bus master: every signal moves right after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge mclk_in);
        wr_s  <= 1'b0;
        repeat (3) @(posedge mclk_in);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk_in);
        rd_s <= 1'b0;
        #1;
        chk_reg(rdata, e);
    endtask

    // Fixed point with six fraction bits; the extra one is dropped only for A=0 without spread
    function automatic logic [19:0] m_exp(input int n, input int a, input int o, input bit ss);
        if (!ss && a == 0) return 20'(2 * n * 64);
        return 20'((2 * n + a + 1) * 64 + (ss ? o : 0));
    endfunction

    task automatic t_reset();
        chk_mul(20'h00000);
        chk_sel(2'h0);
        for (int i = 0; i < 8; i++) rd_chk(8'h14 + 8'(i), PFM_RESET_VAL);
        $display("Test reset done");
    endtask

    task automatic t_regs();
        for (int i = 0; i < 4; i++) wr(8'h16 + 8'(i), 8'h5A + 8'(i));
        for (int i = 0; i < 4; i++) rd_chk(8'h16 + 8'(i), 8'h5A + 8'(i));
        wr(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00);
        $display("Test registers done");
    endtask

    task automatic t_formula();
        wr(PFM_OFF_LOW0, 8'h23);
        wr(PFM_OFF_HIGH0, 8'h01);
        chk_mul(m_exp(291, 0, 0, 0));
        wr(PFM_OFF_HIGH0, 8'h51);
        chk_mul(m_exp(291, 5, 0, 0));
        wr(PFM_OFF_SPREAD0, 8'h10);
        wr(PFM_OFF_SPREAD_EN, 8'h01);
        chk_mul(m_exp(291, 5, 16, 1));
        wr(PFM_OFF_HIGH0, 8'h01);
        chk_mul(m_exp(291, 0, 16, 1));
        wr(PFM_OFF_LOW0, 8'hFF);
        wr(PFM_OFF_HIGH0, 8'hFF);
        wr(PFM_OFF_SPREAD0, 8'hFF);
        chk_mul(m_exp(4095, 15, 255, 1));
        rd_chk(PFM_OFF_MUL_LO, 8'h7F);
        rd_chk(PFM_OFF_MUL_HI, 8'h04);
        wr(PFM_OFF_SPREAD_EN, 8'h00);
        chk_mul(m_exp(4095, 15, 255, 0));
        $display("Test formula done");
    endtask

    task automatic t_select();
        wr(PFM_OFF_LOW2, 8'h40);
        wr(PFM_OFF_HIGH2, 8'h31);
        wr(PFM_OFF_SPREAD0 + 8'h02, 8'h08);
        chk_mul(m_exp(4095, 15, 0, 0));
        @(posedge mclk_in);
        sel    <= 2'h2;
        sel_en <= 1'b1;
        repeat (7) @(posedge mclk_in);
        #1;
        chk_sel(2'h2);
        chk_mul(m_exp(320, 3, 8, 0));
        rd_chk(PFM_OFF_STATUS, 8'h02);
        wr(PFM_OFF_SPREAD_EN, 8'h01);
        chk_mul(m_exp(320, 3, 8, 1));
        wr(PFM_OFF_SPREAD_EN, 8'h00);
        @(posedge mclk_in);
        sel_en <= 1'b0;
        multi_function_control_mode    <= 1'b1;
        repeat (7) @(posedge mclk_in);
        #1;
        chk_sel(2'h0);
        chk_mul(m_exp(4095, 15, 0, 0));
        @(posedge mclk_in);
        multi_function_control_mode    <= 1'b0;
        repeat (7) @(posedge mclk_in);
        #1;
        chk_sel(2'h0);
        $display("Test select done");
    endtask

    // Reset in mid-run must clear the integer and addend registers of every set written so far
    task automatic t_midreset();
        @(posedge mclk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        #1;
        t_reset();
    endtask

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk_in);
        rstn_in <= 1'b1;
        #1;
        t_reset();
        t_regs();
        t_formula();
        t_select();
        t_midreset();
        finish_test();
    end

    // The tests take well under 300 cycles
    initial begin
        #(3000 * 100);
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
